// file: src/input_fault_latch_status.sv
// Latched input fault summary and channel 1 detail registers.
`timescale 1ns/1ps
module input_fault_latch_status (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Control port
   input  wire logic        regRead,
   input  wire logic        regWrite,
   input  wire logic [7:0]  regAddr,
   input  wire logic [7:0]  regWdata,
   output logic      [7:0]  rdData,
   output logic             rdValid,
   // Channel 1 fault detectors
   input  wire logic        ch1OpenFault,
   input  wire logic        ch1PairShort,
   input  wire logic        ch1PosGndShort,
   input  wire logic        ch1NegGndShort,
   input  wire logic        ch1PosBiasShort,
   input  wire logic        ch1NegBiasShort,
   input  wire logic        ch1PosVbatShort,
   input  wire logic        ch1NegVbatShort,
   // Other fault sources
   input  wire logic        ch2AnyFault,
   input  wire logic        vbatBelowBiasShort,
   // Channel 1 diagnostic interrupt request
   output logic             ch1DiagIrq
);

   function automatic logic addrHit(input logic [7:0] addr,
                                    input logic [7:0] target);
      addrHit = (addr == target);
   endfunction : addrHit

   logic [7:0] ch1Events;
   logic [7:0] ch1Clear;
   logic [7:0] ch1Detail;
   logic [7:0] summarySet;
   logic [7:0] summaryClear;
   logic [7:0] summaryFlags;
   logic [7:0] maskValue;
   logic [7:0] readMux;
   logic [7:0] rdData_q;
   logic       rdValid_q;
   logic       irq_q;
   logic       irq_d;

   wire        readSummary = regRead &&
                             addrHit(regAddr, fault_latch_pkg::SUMMARY_ADDR);
   wire        readCh1     = regRead &&
                             addrHit(regAddr, fault_latch_pkg::CH1_DETAIL_ADDR);
   wire        readThird   = regRead &&
                             addrHit(regAddr, fault_latch_pkg::THIRD_LATCH_ADDR);
   wire        readMask    = regRead &&
                             addrHit(regAddr, fault_latch_pkg::SECOND_MASK_ADDR);
   wire        writeMask   = regWrite &&
                             addrHit(regAddr, fault_latch_pkg::SECOND_MASK_ADDR);

   // Channel 1 detector events in register bit order.
   always_comb begin
      ch1Events = '0;
      ch1Events[fault_latch_pkg::CH1_OPEN_BIT]     = ch1OpenFault;
      ch1Events[fault_latch_pkg::CH1_PAIR_BIT]     = ch1PairShort;
      ch1Events[fault_latch_pkg::CH1_POS_GND_BIT]  = ch1PosGndShort;
      ch1Events[fault_latch_pkg::CH1_NEG_GND_BIT]  = ch1NegGndShort;
      ch1Events[fault_latch_pkg::CH1_POS_BIAS_BIT] = ch1PosBiasShort;
      ch1Events[fault_latch_pkg::CH1_NEG_BIAS_BIT] = ch1NegBiasShort;
      ch1Events[fault_latch_pkg::CH1_POS_VBAT_BIT] = ch1PosVbatShort;
      ch1Events[fault_latch_pkg::CH1_NEG_VBAT_BIT] = ch1NegVbatShort;
   end

   // The negative battery short flag clears only on the third latch read.
   always_comb begin
      ch1Clear = {8{readCh1}};
      ch1Clear[fault_latch_pkg::CH1_NEG_VBAT_BIT] = readThird;
   end

   // Reserved summary bits never get a set, so they stay at zero.
   always_comb begin
      summarySet = '0;
      summarySet[fault_latch_pkg::SUM_CH1_BIT]  = |ch1Events;
      summarySet[fault_latch_pkg::SUM_CH2_BIT]  = ch2AnyFault;
      summarySet[fault_latch_pkg::SUM_VBAT_BIT] = vbatBelowBiasShort;
   end

   assign summaryClear = {8{readSummary}};

   fault_flag_bank #(
      .WIDTH   (fault_latch_pkg::DATA_W)
   ) u_ch1Bank (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .setIn   (ch1Events),
      .clearIn (ch1Clear),
      .flags   (ch1Detail)
   );

   fault_flag_bank #(
      .WIDTH   (fault_latch_pkg::DATA_W)
   ) u_summaryBank (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .setIn   (summarySet),
      .clearIn (summaryClear),
      .flags   (summaryFlags)
   );

   diag_mask_reg #(
      .WIDTH     (fault_latch_pkg::DATA_W),
      .RESET_VAL (fault_latch_pkg::SECOND_MASK_RESET)
   ) u_mask (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .wrEn    (writeMask),
      .wrData  (regWdata),
      .value   (maskValue)
   );

   // Readback returns the value held before this read's clear takes effect.
   assign readMux =
      readSummary ? (summaryFlags & fault_latch_pkg::SUMMARY_USED_MASK) :
      readCh1     ? ch1Detail :
      readMask    ? maskValue :
                    fault_latch_pkg::IDLE_READ_DATA;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdData_q  <= fault_latch_pkg::IDLE_READ_DATA;
         rdValid_q <= 1'b0;
      end else begin
         rdData_q  <= regRead ? readMux : rdData_q;
         rdValid_q <= regRead;
      end
   end

   assign irq_d = (|ch1Detail) &
                  ~maskValue[fault_latch_pkg::MASK_CH1_BIT];

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   assign rdData     = rdData_q;
   assign rdValid    = rdValid_q;
   assign ch1DiagIrq = irq_q;

   // Checks of the latching and readback behaviour.
   default clocking cb @(posedge sys_clk);
   endclocking

   default disable iff (!rst_n);

   property p_reset_clear;
      !$past(rst_n) |->
         summaryFlags == fault_latch_pkg::SUMMARY_RESET &&
         ch1Detail == fault_latch_pkg::CH1_DETAIL_RESET &&
         !ch1DiagIrq;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("Latched flags not cleared by reset.");

   property p_sum_ch1;
      (|ch1Events) |=> summaryFlags[fault_latch_pkg::SUM_CH1_BIT] ##1
         (rdData[fault_latch_pkg::SUM_CH1_BIT] || !$past(readSummary));
   endproperty
   a_sum_ch1: assert property (p_sum_ch1)
      else $error("Channel 1 summary flag missed a fault.");

   property p_sum_ch2;
      ch2AnyFault |=> summaryFlags[fault_latch_pkg::SUM_CH2_BIT];
   endproperty
   a_sum_ch2: assert property (p_sum_ch2)
      else $error("Channel 2 summary flag missed a fault.");

   property p_sum_vbat;
      vbatBelowBiasShort ##1 !readSummary[*2] |->
         summaryFlags[fault_latch_pkg::SUM_VBAT_BIT];
   endproperty
   a_sum_vbat: assert property (p_sum_vbat)
      else $error("Battery short summary flag not held.");

   property p_sum_reserved;
      readSummary |=> rdValid && rdData[5:2] == 4'h0 && !rdData[0];
   endproperty
   a_sum_reserved: assert property (p_sum_reserved)
      else $error("Reserved summary bits read non-zero.");

   property p_ch1_set;
      (ch1Events != 8'h00) |=>
         (ch1Detail & $past(ch1Events)) == $past(ch1Events);
   endproperty
   a_ch1_set: assert property (p_ch1_set)
      else $error("Channel 1 detail flag missed its fault.");

   property p_ch1_read_clear;
      readCh1 && ch1Events == 8'h00 |=>
         ch1Detail[7:1] == 7'h00 && rdData == $past(ch1Detail);
   endproperty
   a_ch1_read_clear: assert property (p_ch1_read_clear)
      else $error("Detail read did not return and clear flags.");

   property p_neg_vbat_third;
      readThird && !ch1NegVbatShort |=>
         !ch1Detail[fault_latch_pkg::CH1_NEG_VBAT_BIT];
   endproperty
   a_neg_vbat_third: assert property (p_neg_vbat_third)
      else $error("Negative battery flag not cleared by third read.");

   property p_neg_vbat_keep;
      ch1Detail[fault_latch_pkg::CH1_NEG_VBAT_BIT] && !readThird |=>
         ch1Detail[fault_latch_pkg::CH1_NEG_VBAT_BIT];
   endproperty
   a_neg_vbat_keep: assert property (p_neg_vbat_keep)
      else $error("Negative battery flag cleared without third read.");

   property p_irq_mask;
      ##1 ch1DiagIrq == ($past(|ch1Detail) &&
                         !$past(maskValue[fault_latch_pkg::MASK_CH1_BIT]));
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("Channel 1 interrupt does not follow flags and mask.");

   property p_hold_open;
      ch1Detail[fault_latch_pkg::CH1_OPEN_BIT] && !readCh1 |=>
         ch1Detail[fault_latch_pkg::CH1_OPEN_BIT];
   endproperty
   a_hold_open: assert property (p_hold_open)
      else $error("Open input flag lost without a read.");

   property p_set_beats_clear;
      readSummary && ch2AnyFault |=>
         summaryFlags[fault_latch_pkg::SUM_CH2_BIT];
   endproperty
   a_set_beats_clear: assert property (p_set_beats_clear)
      else $error("Event lost in the cycle of its clearing read.");

   property p_rd_valid;
      ##1 rdValid == $past(regRead);
   endproperty
   a_rd_valid: assert property (p_rd_valid)
      else $error("Read valid does not follow the read strobe.");

   property p_rd_hold;
      !regRead |=> $stable(rdData);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("Read data changed without a read.");

   property p_sum_read_clear;
      readSummary && summarySet == 8'h00 |=>
         summaryFlags == fault_latch_pkg::SUMMARY_RESET &&
         rdData == $past(summaryFlags);
   endproperty
   a_sum_read_clear: assert property (p_sum_read_clear)
      else $error("Summary read did not return and clear flags.");

   property p_sum_reserved_flags;
      (summaryFlags & ~fault_latch_pkg::SUMMARY_USED_MASK) == 8'h00;
   endproperty
   a_sum_reserved_flags: assert property (p_sum_reserved_flags)
      else $error("Reserved summary flag became set.");

   property p_mask_write;
      writeMask |=> maskValue == $past(regWdata);
   endproperty
   a_mask_write: assert property (p_mask_write)
      else $error("Mask register did not take the written value.");

   property p_irq_masked;
      maskValue[fault_latch_pkg::MASK_CH1_BIT] |=> !ch1DiagIrq;
   endproperty
   a_irq_masked: assert property (p_irq_masked)
      else $error("Channel 1 interrupt raised while masked.");

   property p_ch1_no_spurious;
      ##1 (ch1Detail & ~$past(ch1Detail) & ~$past(ch1Events)) == 8'h00;
   endproperty
   a_ch1_no_spurious: assert property (p_ch1_no_spurious)
      else $error("Channel 1 detail flag set without its fault.");

   property p_sum_no_spurious;
      ##1 (summaryFlags & ~$past(summaryFlags) &
           ~$past(summarySet)) == 8'h00;
   endproperty
   a_sum_no_spurious: assert property (p_sum_no_spurious)
      else $error("Summary flag set without a fault.");

   property p_third_read_data;
      readThird |=> rdValid && rdData == fault_latch_pkg::IDLE_READ_DATA;
   endproperty
   a_third_read_data: assert property (p_third_read_data)
      else $error("Third latch read returned unexpected data.");

   c_ch1_fault_read: cover property (
      ch1OpenFault ##1 !ch1OpenFault ##[1:4] readCh1);
   c_third_clear: cover property (
      ch1Detail[fault_latch_pkg::CH1_NEG_VBAT_BIT] && readThird);
   c_masked_irq: cover property (
      (|ch1Detail) && maskValue[fault_latch_pkg::MASK_CH1_BIT]);
   c_summary_read: cover property (
      readSummary && summaryFlags[fault_latch_pkg::SUM_VBAT_BIT]);
   c_clear_meets_set: cover property (
      readCh1 && ch1PairShort);

endmodule : input_fault_latch_status

// file: src/fault_latch_pkg.sv
// Constants shared by the input fault latch status block.
// What this block does
// - Read-only channel summary register at 0x2D, all bits zero after reset.
// - Summary bit 7 latches when any channel 1 fault occurred; clears on read.
// - Summary bit 6 latches when any channel 2 fault occurred; clears on read.
// - Summary bit 1 latches on battery short while battery below bias.
// - Summary bits 5..2 and 0 read zero; software writes only zero there.
// - Read-only channel 1 detail register at 0x2E, all bits zero after reset.
// - Detail bit 7 latches on a channel 1 open input.
// - Detail bit 6 latches on channel 1 inputs shorted together.
// - Detail bits 5 and 4 latch on positive or negative input ground short.
// - Detail bits 3 and 2 latch on positive or negative input bias short.
// - Detail bits 1 and 0 latch on positive or negative battery short.
// - Detail bit 0 clears on reading the third latched register, address 54.
// - Channel 1 fault interrupt suppressed while mask register bit 7 is one.
package fault_latch_pkg;

   localparam int             ADDR_W             = 8;
   localparam int             DATA_W             = 8;

   // Register addresses on page 0.
   localparam logic [7:0]     SECOND_MASK_ADDR   = 8'h2A;
   localparam logic [7:0]     SUMMARY_ADDR       = 8'h2D;
   localparam logic [7:0]     CH1_DETAIL_ADDR    = 8'h2E;
   localparam logic [7:0]     THIRD_LATCH_ADDR   = 8'h36;

   // Reset values.
   localparam logic [7:0]     SUMMARY_RESET      = 8'h00;
   localparam logic [7:0]     CH1_DETAIL_RESET   = 8'h00;
   localparam logic [7:0]     SECOND_MASK_RESET  = 8'h03;
   localparam logic [7:0]     IDLE_READ_DATA     = 8'h00;

   // Summary register fields.
   localparam int             SUM_CH1_BIT        = 7;
   localparam int             SUM_CH2_BIT        = 6;
   localparam int             SUM_VBAT_BIT       = 1;
   localparam logic [7:0]     SUMMARY_USED_MASK  = 8'hC2;

   // Channel 1 detail register fields.
   localparam int             CH1_OPEN_BIT       = 7;
   localparam int             CH1_PAIR_BIT       = 6;
   localparam int             CH1_POS_GND_BIT    = 5;
   localparam int             CH1_NEG_GND_BIT    = 4;
   localparam int             CH1_POS_BIAS_BIT   = 3;
   localparam int             CH1_NEG_BIAS_BIT   = 2;
   localparam int             CH1_POS_VBAT_BIT   = 1;
   localparam int             CH1_NEG_VBAT_BIT   = 0;

   // Second mask register field.
   localparam int             MASK_CH1_BIT       = 7;

endpackage : fault_latch_pkg

// file: src/fault_flag_bank.sv
// A bank of sticky fault flags with per-bit set and clear.
`timescale 1ns/1ps
module fault_flag_bank #(
   parameter int              WIDTH = 8
) (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   // Events and clears
   input  wire logic [WIDTH-1:0]  setIn,
   input  wire logic [WIDTH-1:0]  clearIn,
   // Latched state
   output logic      [WIDTH-1:0]  flags
);

   logic [WIDTH-1:0] flags_q;
   logic [WIDTH-1:0] flags_d;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_flag
         // A set in the clearing cycle wins, so no event is lost.
         assign flags_d[i] = setIn[i] | (flags_q[i] & ~clearIn[i]);
      end
   endgenerate

   // One process owns the whole flag vector.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         flags_q <= '0;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign flags = flags_q;

endmodule : fault_flag_bank

// file: src/diag_mask_reg.sv
// A writable mask register with a fixed reset value.
`timescale 1ns/1ps
module diag_mask_reg #(
   parameter int                 WIDTH     = 8,
   parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   // Write port
   input  wire logic              wrEn,
   input  wire logic [WIDTH-1:0]  wrData,
   // Stored value
   output logic      [WIDTH-1:0]  value
);

   logic [WIDTH-1:0] value_q;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         value_q <= RESET_VAL;
      end else if (wrEn) begin
         value_q <= wrData;
      end
   end

   assign value = value_q;

endmodule : diag_mask_reg

// file: sim/tb.sv
// Self-checking random and directed testbench for the fault latch block.
`timescale 1ns/1ps
module tb;
   localparam int MAX_CYCLES = 6000;
   logic       sys_clk;
   logic       rst_n;
   logic       regRead;
   logic       regWrite;
   logic [7:0] regAddr;
   logic [7:0] regWdata;
   logic [7:0] rdData;
   logic       rdValid;
   logic       ch1DiagIrq;
   logic [9:0] evNow;
   logic [9:0] holdEv;
   logic [9:0] evIn;
   logic [7:0] detM;
   logic [7:0] sumM;
   logic [7:0] maskM;
   integer     seed;
   int         n_mismatch;
   int         tests_run;
   int         cycles;

   assign evIn = evNow | holdEv;

   input_fault_latch_status uut (
      .sys_clk            (sys_clk),
      .rst_n              (rst_n),
      .regRead            (regRead),
      .regWrite           (regWrite),
      .regAddr            (regAddr),
      .regWdata           (regWdata),
      .rdData             (rdData),
      .rdValid            (rdValid),
      .ch1OpenFault       (evIn[7]),
      .ch1PairShort       (evIn[6]),
      .ch1PosGndShort     (evIn[5]),
      .ch1NegGndShort     (evIn[4]),
      .ch1PosBiasShort    (evIn[3]),
      .ch1NegBiasShort    (evIn[2]),
      .ch1PosVbatShort    (evIn[1]),
      .ch1NegVbatShort    (evIn[0]),
      .ch2AnyFault        (evIn[9]),
      .vbatBelowBiasShort (evIn[8]),
      .ch1DiagIrq         (ch1DiagIrq)
   );

   always #12.5 sys_clk = ~sys_clk;

   // Summary bits that a set of detector events must raise.
   function automatic logic [7:0] sum_of(input logic [9:0] ev);
      return {|ev[7:0], ev[9], 4'h0, ev[8], 1'b0};
   endfunction : sum_of

   task automatic chk8(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk8

   task automatic chk1(input string name, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %b seen %b", name, exp, got);
      end
   endtask : chk1

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   // Every task starts and ends just after a rising edge.
   task automatic irq_chk();
      chk1("ch1DiagIrq", (|detM) & ~maskM[7], ch1DiagIrq);
   endtask : irq_chk

   task automatic fault(input logic [9:0] ev);
      evNow = ev;
      @(posedge sys_clk);
      #2;
      evNow = '0;
      detM = detM | ev[7:0] | holdEv[7:0];
      sumM = sumM | sum_of(ev | holdEv);
      @(posedge sys_clk);
      #2;
      irq_chk();
   endtask : fault

   task automatic rd(input logic [7:0] addr);
      logic [7:0] exp;
      exp = (addr == fault_latch_pkg::SUMMARY_ADDR)     ? sumM :
            (addr == fault_latch_pkg::CH1_DETAIL_ADDR)  ? detM :
            (addr == fault_latch_pkg::SECOND_MASK_ADDR) ? maskM : 8'h00;
      regRead = 1'b1;
      regAddr = addr;
      @(posedge sys_clk);
      #2;
      regRead = 1'b0;
      if (addr == fault_latch_pkg::SUMMARY_ADDR) sumM = sum_of(holdEv);
      if (addr == fault_latch_pkg::CH1_DETAIL_ADDR) detM &= 8'h01;
      if (addr == fault_latch_pkg::THIRD_LATCH_ADDR) detM &= 8'hFE;
      detM |= holdEv[7:0];
      chk1("rdValid", 1'b1, rdValid);
      chk8($sformatf("read of %h", addr), exp, rdData);
      @(posedge sys_clk);
      #2;
      chk1("rdValid", 1'b0, rdValid);
      irq_chk();
   endtask : rd

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      regWrite = 1'b1;
      regAddr  = addr;
      regWdata = data;
      @(posedge sys_clk);
      #2;
      regWrite = 1'b0;
      if (addr == fault_latch_pkg::SECOND_MASK_ADDR) maskM = data;
      @(posedge sys_clk);
      #2;
      irq_chk();
   endtask : wr

   task automatic do_reset(input int n);
      rst_n = 1'b0;
      repeat (n) @(posedge sys_clk);
      #2;
      rst_n = 1'b1;
      detM  = fault_latch_pkg::CH1_DETAIL_RESET;
      sumM  = fault_latch_pkg::SUMMARY_RESET;
      maskM = fault_latch_pkg::SECOND_MASK_RESET;
   endtask : do_reset

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == MAX_CYCLES) begin
         n_mismatch++;
         complete_run();
      end
   end

   initial begin
      logic [9:0] ev;
      sys_clk = 1'b0;
      rst_n = 1'b0;
      {regRead, regWrite, regAddr, regWdata} = '0;
      evNow = '0;
      holdEv = '0;
      seed = 67;
      n_mismatch = 0;
      tests_run = 0;
      cycles = 0;
      do_reset(20);
      rd(fault_latch_pkg::SUMMARY_ADDR);
      rd(fault_latch_pkg::CH1_DETAIL_ADDR);
      rd(fault_latch_pkg::SECOND_MASK_ADDR);
      rd(8'h10);
      // Each channel 1 detector alone, then the clearing reads.
      for (int i = 0; i < 8; i++) begin
         fault(10'(1 << i));
         rd(fault_latch_pkg::CH1_DETAIL_ADDR);
         rd(fault_latch_pkg::SUMMARY_ADDR);
         rd(fault_latch_pkg::CH1_DETAIL_ADDR);
         rd(fault_latch_pkg::THIRD_LATCH_ADDR);
         rd(fault_latch_pkg::CH1_DETAIL_ADDR);
      end
      fault(10'h200);
      wr(fault_latch_pkg::SUMMARY_ADDR, 8'h00);
      fault(10'h100);
      rd(fault_latch_pkg::SUMMARY_ADDR);
      rd(fault_latch_pkg::SUMMARY_ADDR);
      // A fault that persists across reads keeps its flag set.
      holdEv = 10'h040;
      fault(10'h000);
      rd(fault_latch_pkg::CH1_DETAIL_ADDR);
      rd(fault_latch_pkg::CH1_DETAIL_ADDR);
      holdEv = '0;
      rd(fault_latch_pkg::CH1_DETAIL_ADDR);
      rd(fault_latch_pkg::CH1_DETAIL_ADDR);
      fault(10'h080);
      wr(fault_latch_pkg::SECOND_MASK_ADDR, 8'h83);
      rd(fault_latch_pkg::SECOND_MASK_ADDR);
      wr(fault_latch_pkg::SECOND_MASK_ADDR, 8'h03);
      // Random events interleaved with reads and mask writes.
      for (int k = 0; k < 120; k++) begin
         ev = 10'($random(seed));
         if (ev[2]) fault(ev);
         case (ev[9:8] ^ ev[1:0])
            2'h0: rd(fault_latch_pkg::CH1_DETAIL_ADDR);
            2'h1: rd(fault_latch_pkg::SUMMARY_ADDR);
            2'h2: rd(fault_latch_pkg::THIRD_LATCH_ADDR);
            default: wr(fault_latch_pkg::SECOND_MASK_ADDR,
                        {ev[5], 7'h03});
         endcase
      end
      fault(10'h3FF);
      do_reset(3);
      rd(fault_latch_pkg::SUMMARY_ADDR);
      rd(fault_latch_pkg::CH1_DETAIL_ADDR);
      complete_run();
   end
endmodule : tb
